// File: logic/acds_cfg.svh
`ifndef ACDS_CFG_SVH
`define ACDS_CFG_SVH
// register word indices on the avalon address
`define ACDS_IDX_TIMING 4'h0
`define ACDS_IDX_CHAN_DMA 4'h1
`define ACDS_IDX_CALIB 4'h2
`define ACDS_IDX_PTR_LOW 4'h3
`define ACDS_IDX_PTR_MID 4'h4
`define ACDS_IDX_PTR_PAGE 4'h5
`define ACDS_IDX_RESULT 4'h6
`define ACDS_IDX_REF_DAC 4'h7
// conv_ctrl_timing fields
`define ACDS_F_PWR_HI 7
`define ACDS_F_PWR_LO 6
`define ACDS_F_DIV_HI 5
`define ACDS_F_DIV_LO 4
`define ACDS_F_ACQ_HI 3
`define ACDS_F_ACQ_LO 2
`define ACDS_F_EXT_TRIG 1
`define ACDS_F_TMR_TRIG 0
// conv_ctrl_channel_dma fields
`define ACDS_F_DONE 7
`define ACDS_F_DMA 6
`define ACDS_F_CONT 5
`define ACDS_F_START 4
`define ACDS_F_CH_HI 3
`define ACDS_F_CH_LO 0
// reset values and codes
`define ACDS_REG_RST 8'h00
`define ACDS_PTR_RST 24'h00_0000
`define ACDS_RD_RST 32'h0000_0000
`define ACDS_PWR_DOWN 2'h0
`define ACDS_DIV_SEL_1 2'h0
`define ACDS_DIV_SEL_2 2'h1
`define ACDS_DIV_SEL_4 2'h2
`define ACDS_DIV1_TOP 3'h0
`define ACDS_DIV2_TOP 3'h1
`define ACDS_DIV4_TOP 3'h3
`define ACDS_DIV8_TOP 3'h7
// conversion timing in converter clocks
`define ACDS_SYNC_CLKS 5'h1
`define ACDS_CONV_CLKS 5'hf
// capture list layout
`define ACDS_STOP_ID 4'hf
`define ACDS_ADDR_STEP 24'h00_0001
`define ACDS_ENTRY_STEP 24'h00_0002
`define ACDS_PIPE_FILL 2'h2
`endif

// File: logic/acds_pkg.sv
package acds_pkg;
  typedef enum logic [2:0] {
    D_IDLE,
    D_WR_HI,
    D_WR_LO,
    D_RD,
    D_WAIT
  } acds_dma_state_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic we_n;
    logic oe_n;
    logic data_oe;
  } acds_xm_t;
endpackage

// File: logic/acds_conv_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "acds_cfg.svh"
module acds_conv_timer
  import acds_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [1:0] i_acq_sel,
  output logic o_busy,
  output logic o_hold,
  output logic o_done
);
  logic [4:0] cnt_q;
  logic [1:0] acq_q;
  logic busy_q;
  logic hold_q;
  logic done_q;
  // sync tick, then acquisition ticks, then successive approximation
  wire [4:0] acq_end = `ACDS_SYNC_CLKS + {3'h0, acq_q};
  wire [4:0] conv_last = acq_end + `ACDS_CONV_CLKS;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 5'h0;
      acq_q <= 2'h0;
      busy_q <= 1'h0;
      hold_q <= 1'h0;
      done_q <= 1'h0;
    end else if (i_clk_en) begin
      done_q <= 1'h0;
      if (i_start) begin
        busy_q <= 1'h1;
        hold_q <= 1'h0;
        // a tick on the start edge is the first converter clock, so /1 restarts lose none
        cnt_q <= {4'h0, i_tick};
        acq_q <= i_acq_sel;
      end else if (busy_q && i_tick) begin
        cnt_q <= cnt_q + 5'h1;
        if (cnt_q == acq_end) begin
          hold_q <= 1'h1;
        end
        if (cnt_q == conv_last) begin
          busy_q <= 1'h0;
          hold_q <= 1'h0;
          done_q <= 1'h1;
        end
      end
    end
  end

  assign o_busy = busy_q;
  assign o_hold = hold_q;
  assign o_done = done_q;

  logic [4:0] tk_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tk_q <= 5'h0;
    end else if (i_clk_en) begin
      if (i_start) begin
        tk_q <= {4'h0, i_tick};
      end else if (busy_q && i_tick) begin
        tk_q <= tk_q + 5'h1;
      end
    end
  end

  AST_CONV_TICKS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(done_q) |-> tk_q == 5'h11 + {3'h0, acq_q})
    else $error("conversion length is not 17 plus extra acquisition ticks");
  AST_ACQ_ONE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ($rose(hold_q) && acq_q == 2'h0) |-> tk_q == 5'h2)
    else $error("one-clock acquisition did not switch to hold after two ticks");
  COV_CONV: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(done_q));
endmodule
`default_nettype wire

// File: logic/acds_top.sv
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "acds_cfg.svh"
module acds_top
  import acds_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_timer_trig,
  input wire logic i_conv_trig_pin,
  input wire logic [11:0] i_sar_result,
  output logic [3:0] o_sar_channel,
  output logic o_sar_hold,
  output logic o_ref_enable,
  input wire acds_xm_t i_core_xm,
  output logic [7:0] o_core_xm_rdata,
  input wire logic [7:0] i_xm_rdata,
  output acds_xm_t o_xm,
  output logic o_capture_active
);
  logic wait_q;
  logic [31:0] rd_q;
  logic [7:0] conv_ctrl_timing_q;
  logic [7:0] conv_ctrl_channel_dma_q;
  logic [7:0] conv_ctrl_calib_q;
  logic [7:0] xfer_pointer_low_q;
  logic [7:0] xfer_pointer_mid_q;
  logic [7:0] xfer_pointer_page_q;
  logic [15:0] result_q;
  logic [1:0] dac_en_q;
  logic conv_done_flag_q;
  logic pend_q;
  logic ref_q;
  logic [2:0] div_cnt_q;
  logic converter_clock_q;
  logic [2:0] trig_s_q;
  logic trig_lvl_q;
  logic run_q;
  logic stop_q;
  logic fv_q;
  logic cv_q;
  logic [3:0] fid_q;
  logic [3:0] sar_ch_q;
  logic [3:0] rch_q;
  logic [11:0] rres_q;
  logic [23:0] fp_q;
  logic [23:0] wp_q;
  logic [1:0] cyc_q;
  logic [7:0] core_rd_q;
  acds_dma_state_t dst_q;
  acds_dma_state_t dst_d;
  acds_xm_t xm_q;
  acds_xm_t xm_d;
  logic busy_w;
  logic hold_w;
  logic done_w;

  // bus decode
  wire req = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ~wait_q & i_avs_byteenable[0];
  wire [7:0] wb = i_avs_writedata[7:0];
  wire sel_tim = i_avs_address == `ACDS_IDX_TIMING;
  wire sel_chn = i_avs_address == `ACDS_IDX_CHAN_DMA;
  wire sel_cal = i_avs_address == `ACDS_IDX_CALIB;
  wire sel_pl = i_avs_address == `ACDS_IDX_PTR_LOW;
  wire sel_pm = i_avs_address == `ACDS_IDX_PTR_MID;
  wire sel_pp = i_avs_address == `ACDS_IDX_PTR_PAGE;
  wire sel_res = i_avs_address == `ACDS_IDX_RESULT;
  wire sel_ref = i_avs_address == `ACDS_IDX_REF_DAC;

  // control fields
  wire [1:0] pmode = conv_ctrl_timing_q[`ACDS_F_PWR_HI:`ACDS_F_PWR_LO];
  wire [1:0] dsel = conv_ctrl_timing_q[`ACDS_F_DIV_HI:`ACDS_F_DIV_LO];
  wire [1:0] acq = conv_ctrl_timing_q[`ACDS_F_ACQ_HI:`ACDS_F_ACQ_LO];
  wire pwr = pmode != `ACDS_PWR_DOWN;
  wire dma_en = conv_ctrl_channel_dma_q[`ACDS_F_DMA];
  wire cont = conv_ctrl_channel_dma_q[`ACDS_F_CONT];
  wire [23:0] ptr = {xfer_pointer_page_q, xfer_pointer_mid_q, xfer_pointer_low_q};

  // converter clock divider
  wire [2:0] div_top = (dsel == `ACDS_DIV_SEL_1) ? `ACDS_DIV1_TOP :
                       (dsel == `ACDS_DIV_SEL_2) ? `ACDS_DIV2_TOP :
                       (dsel == `ACDS_DIV_SEL_4) ? `ACDS_DIV4_TOP : `ACDS_DIV8_TOP;
  wire div_last = div_cnt_q >= div_top;

  // conversion start sources
  wire ext_rise = trig_s_q[1] & trig_s_q[2] & ~trig_lvl_q;
  wire want = pend_q | cont
            | (conv_ctrl_timing_q[`ACDS_F_TMR_TRIG] & i_timer_trig)
            | (conv_ctrl_timing_q[`ACDS_F_EXT_TRIG] & ext_rise);
  wire go = pwr & (~busy_w | done_w) & want & ~run_q;
  wire launch = go & dma_en;
  wire single_go = go & ~dma_en;
  wire abort = run_q & (~dma_en | ~pwr);
  wire cyc_end = run_q & done_w & ~abort;
  wire dma_fin = cyc_end & stop_q;
  wire dma_next = cyc_end & ~stop_q;
  wire conv_start = single_go | launch | dma_next;
  wire single_done = done_w & ~run_q;
  wire flag_set = single_done | dma_fin;
  wire flag_clr = wr_go & sel_chn & ~wb[`ACDS_F_DONE];
  wire rd_tick = (dst_q == D_RD) & converter_clock_q;
  wire [3:0] rd_id = i_xm_rdata[7:4];
  wire id_stop = rd_id == `ACDS_STOP_ID;

  // result being written: at a cycle boundary it is the fresh one
  wire [3:0] w_ch = cyc_end ? sar_ch_q : rch_q;
  wire [11:0] w_res = cyc_end ? i_sar_result : rres_q;
  wire [23:0] f_addr = launch ? ptr : fp_q;

  // read mux
  wire [7:0] chn_rd = {conv_done_flag_q, conv_ctrl_channel_dma_q[6:5], busy_w | run_q,
                       conv_ctrl_channel_dma_q[3:0]};
  wire [31:0] rd_d = sel_tim ? {24'h00_0000, conv_ctrl_timing_q} :
                     sel_chn ? {24'h00_0000, chn_rd} :
                     sel_cal ? {24'h00_0000, conv_ctrl_calib_q} :
                     sel_pl ? {24'h00_0000, xfer_pointer_low_q} :
                     sel_pm ? {24'h00_0000, xfer_pointer_mid_q} :
                     sel_pp ? {24'h00_0000, xfer_pointer_page_q} :
                     sel_res ? {16'h0000, result_q} :
                     sel_ref ? {30'h0000_0000, dac_en_q} : `ACDS_RD_RST;

  acds_conv_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_tick(converter_clock_q),
    .i_start(conv_start),
    .i_acq_sel(acq),
    .o_busy(busy_w),
    .o_hold(hold_w),
    .o_done(done_w)
  );

  // avalon slave: one wait cycle, then the access completes
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wait_q <= 1'h1;
      rd_q <= `ACDS_RD_RST;
    end else if (i_clk_en) begin
      wait_q <= ~(req & wait_q);
      if (i_avs_read & wait_q) begin
        rd_q <= rd_d;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      conv_ctrl_timing_q <= `ACDS_REG_RST;
      conv_ctrl_calib_q <= `ACDS_REG_RST;
      xfer_pointer_low_q <= `ACDS_REG_RST;
      xfer_pointer_mid_q <= `ACDS_REG_RST;
      xfer_pointer_page_q <= `ACDS_REG_RST;
      dac_en_q <= 2'h0;
    end else if (i_clk_en && wr_go) begin
      if (sel_tim) conv_ctrl_timing_q <= wb;
      if (sel_cal) conv_ctrl_calib_q <= wb;
      if (sel_pl) xfer_pointer_low_q <= wb;
      if (sel_pm) xfer_pointer_mid_q <= wb;
      if (sel_pp) xfer_pointer_page_q <= wb;
      if (sel_ref) dac_en_q <= wb[1:0];
    end
  end

  // channel register, start request, done flag (set beats clear)
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      conv_ctrl_channel_dma_q <= `ACDS_REG_RST;
      pend_q <= 1'h0;
      conv_done_flag_q <= 1'h0;
    end else if (i_clk_en) begin
      if (wr_go && sel_chn) begin
        conv_ctrl_channel_dma_q <= wb;
      end else if (dma_fin) begin
        conv_ctrl_channel_dma_q[`ACDS_F_CONT] <= 1'h0;
      end
      pend_q <= (wr_go & sel_chn & wb[`ACDS_F_START]) | (pend_q & ~go);
      conv_done_flag_q <= flag_set | (conv_done_flag_q & ~flag_clr);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ref_q <= 1'h0;
      div_cnt_q <= 3'h0;
      converter_clock_q <= 1'h0;
      trig_s_q <= 3'h0;
      trig_lvl_q <= 1'h0;
    end else if (i_clk_en) begin
      ref_q <= pwr | (|dac_en_q);
      div_cnt_q <= (div_last | ~pwr) ? 3'h0 : div_cnt_q + 3'h1;
      converter_clock_q <= div_last & pwr;
      trig_s_q <= {trig_s_q[1:0], i_conv_trig_pin};
      if (trig_s_q[1] == trig_s_q[2]) begin
        trig_lvl_q <= trig_s_q[2];
      end
    end
  end

  // capture sequencer: writes, then fetch, then wait for conversion end
  always_comb begin
    dst_d = dst_q;
    unique case (dst_q)
      D_IDLE, D_WAIT: if (launch | dma_next) dst_d = cv_q ? D_WR_HI : D_RD;
      D_WR_HI: if (converter_clock_q) dst_d = D_WR_LO;
      D_WR_LO: if (converter_clock_q) dst_d = D_RD;
      D_RD: if (converter_clock_q) dst_d = D_WAIT;
      default: dst_d = D_IDLE;
    endcase
    if (dma_fin | abort) dst_d = D_IDLE;
  end

  always_comb begin
    xm_d = i_core_xm;
    if (dma_en) begin
      xm_d.addr = f_addr;
      xm_d.wdata = 8'h00;
      xm_d.we_n = 1'h1;
      xm_d.oe_n = 1'h1;
      xm_d.data_oe = 1'h0;
      unique case (dst_d)
        D_WR_HI: begin
          xm_d.addr = wp_q;
          xm_d.wdata = {w_ch, w_res[11:8]};
          xm_d.we_n = 1'h0;
          xm_d.data_oe = 1'h1;
        end
        D_WR_LO: begin
          xm_d.addr = wp_q + `ACDS_ADDR_STEP;
          xm_d.wdata = rres_q[7:0];
          xm_d.we_n = 1'h0;
          xm_d.data_oe = 1'h1;
        end
        D_RD: xm_d.oe_n = 1'h0;
        default: xm_d.oe_n = 1'h1;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      dst_q <= D_IDLE;
      xm_q <= '0;
      core_rd_q <= 8'h00;
    end else if (i_clk_en) begin
      dst_q <= dst_d;
      xm_q <= xm_d;
      core_rd_q <= dma_en ? 8'h00 : i_xm_rdata;
    end
  end

  // pipeline: fetched id -> converting id -> result to write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      run_q <= 1'h0;
      stop_q <= 1'h0;
      fv_q <= 1'h0;
      cv_q <= 1'h0;
      fid_q <= 4'h0;
      sar_ch_q <= 4'h0;
      rch_q <= 4'h0;
      rres_q <= 12'h000;
      fp_q <= `ACDS_PTR_RST;
      wp_q <= `ACDS_PTR_RST;
      cyc_q <= 2'h0;
      result_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (launch) begin
        run_q <= 1'h1;
        stop_q <= 1'h0;
        fv_q <= 1'h0;
        cv_q <= 1'h0;
        fp_q <= ptr;
        wp_q <= ptr;
        cyc_q <= 2'h0;
      end else if (dma_fin | abort) begin
        run_q <= 1'h0;
        stop_q <= 1'h0;
      end else if (dma_next) begin
        cv_q <= fv_q;
        fv_q <= 1'h0;
        sar_ch_q <= fid_q;
        rch_q <= sar_ch_q;
        rres_q <= i_sar_result;
        if (cyc_q != `ACDS_PIPE_FILL) cyc_q <= cyc_q + 2'h1;
      end
      if (rd_tick) begin
        fid_q <= rd_id;
        fv_q <= ~id_stop;
        stop_q <= id_stop;
        fp_q <= fp_q + `ACDS_ENTRY_STEP;
      end
      if ((dst_q == D_WR_LO) && converter_clock_q) begin
        wp_q <= wp_q + `ACDS_ENTRY_STEP;
      end
      if (single_go) begin
        sar_ch_q <= conv_ctrl_channel_dma_q[`ACDS_F_CH_HI:`ACDS_F_CH_LO];
      end
      if (single_done) begin
        result_q <= {sar_ch_q, i_sar_result};
      end
    end
  end

  assign o_avs_readdata = rd_q;
  assign o_avs_waitrequest = wait_q;
  assign o_sar_channel = sar_ch_q;
  assign o_sar_hold = hold_w;
  assign o_ref_enable = ref_q;
  assign o_core_xm_rdata = core_rd_q;
  assign o_xm = xm_q;
  assign o_capture_active = run_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_REF_OFF_RESET: assert property ($past(i_sys_rst) |-> !o_ref_enable)
    else $error("reference on straight after reset");
  AST_REF_AUTO: assert property ((i_clk_en && (pwr || (|dac_en_q))) |=> o_ref_enable)
    else $error("reference not enabled with converter or dac");
  // a write to the timing register may change the ratio mid-spacing
  AST_DIV4: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst || !i_clk_en || (wr_go && sel_tim))
    (converter_clock_q && dsel == `ACDS_DIV_SEL_4 && pwr) |=>
      (!converter_clock_q)[*3] ##1 converter_clock_q)
    else $error("divide-by-4 tick spacing wrong");
  AST_CONT_RESTART: assert property ((i_clk_en && done_w && cont && pwr && !dma_en)
    |=> busy_w)
    else $error("continuous mode did not restart at once");
  AST_FIRST_PTR: assert property ((i_clk_en && launch) |=> (fp_q == $past(ptr))
    && (wp_q == $past(ptr)))
    else $error("capture did not start at the pointer");
  AST_FIRST_WRITE: assert property ((dst_q == D_WR_HI) |-> cyc_q == `ACDS_PIPE_FILL)
    else $error("result written before the third capture cycle");
  AST_WR_PAIR: assert property ((dst_q == D_WR_LO && $past(dst_q) == D_WR_HI)
    |-> o_xm.addr == $past(o_xm.addr) + `ACDS_ADDR_STEP)
    else $error("result bytes not at consecutive addresses");
  AST_STOP_FLAG: assert property ((i_clk_en && dma_fin) |=> conv_done_flag_q && !run_q)
    else $error("capture end did not raise done flag");
  AST_NO_LAST_WRITE: assert property (stop_q |-> (dst_q != D_WR_HI)
    && (dst_q != D_WR_LO))
    else $error("write after stop id was fetched");
  AST_CORE_GATED: assert property ((i_clk_en && dma_en && dst_d == D_IDLE)
    |=> o_xm.we_n && o_xm.oe_n)
    else $error("core access reached memory during capture");
  COV_CAPTURE_DONE: cover property (dma_fin);
  COV_CONT: cover property (done_w && cont && !dma_en ##1 busy_w);
  COV_FIRST_WRITE: cover property (dst_q == D_WR_HI);
endmodule
`default_nettype wire

// File: sim/acds_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
module acds_sram_model
  import acds_pkg::*;
(
  input wire logic i_ref_clk,
  input wire acds_xm_t i_xm,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [int];
  logic [7:0] junk_q = 8'h5a;
  wire logic rd_en = !i_xm.oe_n && i_xm.we_n;
  always @(posedge i_ref_clk) begin
    junk_q <= ~junk_q + 8'h01;
    if (!i_xm.we_n && i_xm.data_oe) begin
      mem[i_xm.addr] = i_xm.wdata;
    end
  end
  // an unselected bus shows a moving pattern, never the last value
  always @* begin
    o_rdata = (rd_en && mem.exists(i_xm.addr)) ? mem[i_xm.addr] : junk_q;
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import acds_pkg::*;
;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } acds_exp_t;
  localparam acds_xm_t xm_idle = '{24'h00_0000, 8'h00, 1'b1, 1'b1, 1'b0};
  logic ref_clk;
  logic sys_rst = 1'b1;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [3:0] avs_a = 4'h0;
  logic [3:0] avs_be = 4'h0;
  logic [31:0] avs_d = 32'h0000_0000;
  logic tmr = 1'b0;
  logic pin = 1'b0;
  logic [11:0] sar = 12'h000;
  logic [7:0] sar_lo = 8'h00;
  acds_xm_t core_xm = xm_idle;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] sch;
  logic shold;
  logic refen;
  logic [7:0] core_rd;
  logic [7:0] mem_rd;
  acds_xm_t xm;
  logic cap;
  logic [31:0] rng = 32'h0000_0054;
  int fail_count = 0;
  int samples_checked = 0;
  acds_exp_t exp_q[$];

  acds_top acds_top_inst (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(1'b1),
    .i_avs_address(avs_a), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
    .i_avs_writedata(avs_d), .i_avs_byteenable(avs_be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_timer_trig(tmr), .i_conv_trig_pin(pin),
    .i_sar_result(sar), .o_sar_channel(sch), .o_sar_hold(shold), .o_ref_enable(refen),
    .i_core_xm(core_xm), .o_core_xm_rdata(core_rd), .i_xm_rdata(mem_rd), .o_xm(xm),
    .o_capture_active(cap)
  );
  acds_sram_model acds_sram_model_inst (.i_ref_clk(ref_clk), .i_xm(xm), .o_rdata(mem_rd));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // analog stand-in: result follows the channel under conversion
  always @(posedge ref_clk) sar <= {~sch, sar_lo};

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_wr <= w;
    avs_rd <= !w;
    avs_a <= a;
    avs_d <= d;
    avs_be <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1, "bus hang");
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdq(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v, m});
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic wait_hold(input logic v, inout int n);
    int k;
    k = 0;
    while (shold !== v && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    n += k;
  endtask

  always @(posedge ref_clk) begin
    if (avs_rd && wreq === 1'b0 && exp_q.size() > 0) begin
      acds_exp_t e;
      e = exp_q.pop_front();
      check(rdata & e.m, e.v, "readdata");
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    int p;
    int n;
    logic [23:0] ba;
    logic [3:0] ids [5];
    logic [7:0] v;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check(refen, 1'b0, "ref off after reset");
    for (int i = 0; i < 9; i++) rdq(4'(i), 32'h0000_0000, 32'hffff_ffff);
    v = 8'(rnd());
    wr(4'h9, {24'h00_0000, v});
    rdq(4'h9, 32'h0000_0000, 32'hffff_ffff);
    bus(1'b1, 4'h2, {24'h00_0000, v}, 4'he);
    rdq(4'h2, 32'h0000_0000, 32'h0000_00ff);
    wr(4'h2, {24'h00_0000, v});
    rdq(4'h2, {24'h00_0000, v}, 32'h0000_00ff);
    wr(4'h7, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    check(refen, 1'b1, "ref on by dac");
    wr(4'h7, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check(refen, 1'b0, "ref off");
    $display("test registers done");
    // settling wait shortened: the block itself does not time it
    for (int i = 0; i < 4; i++) begin
      sar_lo <= 8'(rnd());
      wr(4'h0, {24'h00_0000, 2'h1, 2'(i), 2'(i ^ 2), 2'h0});
      repeat (2) @(posedge ref_clk);
      check(refen, 1'b1, "ref on by converter");
      wr(4'h1, 32'h0000_0030);
      n = 0;
      wait_hold(1'b0, n);
      wait_hold(1'b1, n);
      p = 0;
      wait_hold(1'b0, p);
      wait_hold(1'b1, p);
      check(p, (17 + (i ^ 2)) * (1 << i), "continuous period");
      wr(4'h1, 32'h0000_0000);
      wait_hold(1'b0, n);
      wr(4'h1, 32'h0000_0000);
    end
    $display("test timing done");
    for (int t = 0; t < 2; t++) begin
      sar_lo <= 8'(rnd());
      wr(4'h1, {28'h000_0000, 4'(t + 5)});
      wr(4'h0, {24'h00_0000, 8'h40 | 8'(t + 1)});
      @(posedge ref_clk);
      tmr <= (t == 0);
      pin <= (t == 1);
      @(posedge ref_clk);
      tmr <= 1'b0;
      repeat (3) @(posedge ref_clk);
      pin <= 1'b0;
      n = 0;
      wait_hold(1'b1, n);
      wait_hold(1'b0, n);
      repeat (4) @(posedge ref_clk);
      rdq(4'h6, {16'h0000, 4'(t + 5), ~4'(t + 5), sar_lo}, 32'h0000_ffff);
      rdq(4'h1, 32'h0000_0080, 32'h0000_0080);
      wr(4'h1, 32'h0000_0000);
    end
    $display("test triggers done");
    ba = {8'(rnd()) | 8'h01, 16'(rnd()) & 16'hfffe};
    for (int j = 0; j < 3; j++) ids[j] = 4'(rnd() % 15);
    ids[3] = ids[2];
    ids[4] = 4'hf;
    acds_sram_model_inst.mem[ba - 24'h00_0001] = 8'h77;
    for (int j = 0; j < 5; j++) begin
      acds_sram_model_inst.mem[ba + 2 * j] = {ids[j], 4'h0};
      acds_sram_model_inst.mem[ba + 2 * j + 1] = 8'hee;
    end
    wr(4'h0, 32'h0000_0000);
    wr(4'h3, ba[7:0]);
    wr(4'h4, ba[15:8]);
    wr(4'h5, ba[23:16]);
    wr(4'h1, 32'h0000_0040);
    wr(4'h0, 32'h0000_0040);
    core_xm <= '{ba - 24'h00_0001, 8'h11, 1'b0, 1'b1, 1'b1};
    wr(4'h1, 32'h0000_0050);
    n = 0;
    while (cap !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check(core_rd, 8'h00, "core read gated");
    core_xm <= xm_idle;
    n = 0;
    while (cap !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    check(cap, 1'b0, "capture stops");
    for (int j = 0; j < 5; j++) begin
      if (j < 3) begin
        check(acds_sram_model_inst.mem[ba + 2 * j], {ids[j], ~ids[j]}, "result hi");
        check(acds_sram_model_inst.mem[ba + 2 * j + 1], sar_lo, "result lo");
      end else begin
        check(acds_sram_model_inst.mem[ba + 2 * j], {ids[j], 4'h0}, "tail even");
        check(acds_sram_model_inst.mem[ba + 2 * j + 1], 8'hee, "tail odd");
      end
    end
    check(acds_sram_model_inst.mem[ba - 24'h00_0001], 8'h77, "core write blocked");
    rdq(4'h1, 32'h0000_0080, 32'h0000_00a0);
    wr(4'h1, 32'h0000_0000);
    core_xm <= '{ba - 24'h00_0001, 8'h11, 1'b0, 1'b1, 1'b1};
    repeat (3) @(posedge ref_clk);
    core_xm <= xm_idle;
    repeat (2) @(posedge ref_clk);
    check(acds_sram_model_inst.mem[ba - 24'h00_0001], 8'h11, "core write passes");
    $display("test capture done");
    give_verdict();
  end
endmodule
`default_nettype wire
